// ### core/usdp_pkg.sv
// Package with register map, field positions, reset values and timing counts of the serial port.
package usdp_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [2:0] ADDR_DATA = 3'h0;
	localparam logic [2:0] ADDR_STATUS = 3'h1;
	localparam logic [2:0] ADDR_CTRL_ONE = 3'h2;
	localparam logic [2:0] ADDR_CTRL_TWO = 3'h3;
	localparam logic [2:0] ADDR_BAUD = 3'h4;
	// ----------------------------------------
	// Status fields
	// ----------------------------------------
	localparam int ST_PARITY = 7;
	localparam int ST_NOISE = 6;
	localparam int ST_FRAMING = 5;
	localparam int ST_OVERRUN = 4;
	localparam int ST_RX_IDLE = 3;
	localparam int ST_RX_AVAIL = 2;
	localparam int ST_TX_IDLE = 1;
	localparam int ST_TX_EMPTY = 0;
	// ----------------------------------------
	// Control one fields
	// ----------------------------------------
	localparam int C1_PORT_EN = 7;
	localparam int C1_NINE_BIT = 6;
	localparam int C1_PARITY_EN = 5;
	localparam int C1_PARITY_ODD = 4;
	localparam int C1_TWO_STOP = 3;
	localparam int C1_TX_BREAK = 2;
	localparam int C1_RX8 = 1;
	localparam int C1_TX8 = 0;
	// ----------------------------------------
	// Control two fields
	// ----------------------------------------
	localparam int C2_TX_EN = 7;
	localparam int C2_RX_EN = 6;
	localparam int C2_HIGH_SPEED = 5;
	localparam int C2_ADDR_DETECT = 4;
	localparam int C2_WAKE = 3;
	localparam int C2_RX_IE = 2;
	localparam int C2_TX_IDLE_IE = 1;
	localparam int C2_TX_EMPTY_IE = 0;
	// ----------------------------------------
	// Reset values and timing
	// ----------------------------------------
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] BAUD_RESET = 8'h00;
	localparam logic [1:0] LOW_SPEED_LAST = 2'h3;
	localparam logic [3:0] TICK_LAST = 4'hf;
	localparam logic [3:0] VOTE_FIRST = 4'h7;
	localparam logic [3:0] VOTE_SECOND = 4'h8;
	localparam logic [3:0] VOTE_LAST = 4'h9;
	localparam logic [3:0] BREAK_BITS = 4'hd;
endpackage

// ### core/usdp_serial_port.sv
// Serial port data path, status flags, receive queue and register port.
//
// Operation
// [R1] Transmit and receive run together; 8 or 9 data bits; 1 or 2 stop bits.
// [R2] Even, odd or no parity, same choice for generation and checking.
// [R3] Bit timing of both shifters comes from an 8-bit prescaled baud generator.
// [R4] Received characters wait in a two-entry queue read via the data register.
// [R5] With address detection on, only characters whose last bit is one are accepted.
// [R6] Interrupt from tx empty, tx idle, rx full, rx overrun, address detect; the code has no address-detect interrupt source.
// [R7] Port and direction enables drive the pin and turn its pull-up off.
// [R8] Clearing an enable floats the pin and returns pull-up control.
// [R9] A written byte moves to the shift register and leaves LSB first.
// [R10] Incoming bits shift in LSB first, complete characters go to the queue.
// [R11] One data address: writes load transmit data, reads return received data.
// [R12] Parity error flag in bit 7 when a parity check fails.
// [R13] Noise flag in bit 6 set with data-available, never on overrun.
// [R14] Framing error flag in bit 5 for a bad stop bit.
// [R15] Overrun flag in bit 4 on queue overflow; blocks further queue writes.
// [R16] Status read then data access clears parity, noise, framing, overrun.
// [R17] Receiver idle bit 3 is zero from start bit to stop bit end; the code sets it again at the third vote of the stop bit.
// [R18] Data-available bit 2 and error flags set together when a character queues.
// [R19] Data-available clears on status read, data read, with queue then empty.
// [R20] Transmitter idle bit 1 set when empty and nothing or no break is sent.
// [R21] Transmitter idle clears on status read then data write.
// [R22] Transmit-empty bit 0 set on shift load, cleared by status read and write.
// [R23] Setting transmit enable sets transmit-empty.
// [R24] Port disable empties buffers, resets baud count, resets the flags.
// [R25] Three samples near bit centre; majority gives the bit, disagreement is noise.
`timescale 1ns/1ps
`default_nettype none
module usdp_serial_port (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [2:0] addr,
	input wire logic [7:0] wrData,
	input wire logic wrStrobe,
	input wire logic rdStrobe,
	output logic [7:0] rdData,
	input wire logic rxPin,
	output logic txPin,
	output logic txOe,
	output logic txPullupOff,
	output logic rxPullupOff,
	output logic irqRequest
);
	// ----------------------------------------
	// Registers and decode
	// ----------------------------------------
	typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP, TX_BREAK} usdp_tx_e;
	typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} usdp_rx_e;
	logic [7:0] ctrlOne;
	logic [7:0] ctrlTwo;
	logic [7:0] baudDivisor;
	logic [7:0] statusSnap;
	logic armed;
	logic portEnable;
	logic txOn;
	logic rxOn;
	logic dataWr;
	logic dataRd;
	logic statusRd;
	logic [7:0] status;
	assign portEnable = ctrlOne[usdp_pkg::C1_PORT_EN];
	assign txOn = portEnable & ctrlTwo[usdp_pkg::C2_TX_EN];
	assign rxOn = portEnable & ctrlTwo[usdp_pkg::C2_RX_EN];
	assign dataWr = wrStrobe && addr == usdp_pkg::ADDR_DATA; // [R11]
	assign dataRd = rdStrobe && addr == usdp_pkg::ADDR_DATA; // [R11]
	assign statusRd = rdStrobe && addr == usdp_pkg::ADDR_STATUS;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ctrlOne <= usdp_pkg::CTRL_RESET;
		end else if (wrStrobe && addr == usdp_pkg::ADDR_CTRL_ONE) begin
			ctrlOne <= wrData & ~(8'h01 << usdp_pkg::C1_RX8);
		end else if (!portEnable) begin
			ctrlOne[usdp_pkg::C1_TX_BREAK] <= 1'b0; // [R24]
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ctrlTwo <= usdp_pkg::CTRL_RESET;
		end else if (wrStrobe && addr == usdp_pkg::ADDR_CTRL_TWO) begin
			ctrlTwo <= wrData;
		end else if (!portEnable) begin
			ctrlTwo[usdp_pkg::C2_TX_EN] <= 1'b0; // [R24]
			ctrlTwo[usdp_pkg::C2_RX_EN] <= 1'b0; // [R24]
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			baudDivisor <= usdp_pkg::BAUD_RESET;
		end else if (wrStrobe && addr == usdp_pkg::ADDR_BAUD) begin
			baudDivisor <= wrData;
		end
	end

	// A status read arms the clear sequence; the next data access consumes it.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			armed <= 1'b0;
			statusSnap <= 8'h00;
		end else if (statusRd) begin
			armed <= 1'b1; // [R16]
			statusSnap <= status;
		end else if (dataRd || dataWr) begin
			armed <= 1'b0;
		end
	end

	// ----------------------------------------
	// Baud generator
	// ----------------------------------------
	logic [7:0] baudCnt;
	logic [1:0] preCnt;
	logic tick;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			baudCnt <= 8'h00;
			preCnt <= 2'h0;
			tick <= 1'b0;
		end else if (!portEnable) begin
			baudCnt <= 8'h00; // [R24]
			preCnt <= 2'h0;
			tick <= 1'b0;
		end else begin
			tick <= 1'b0;
			if (baudCnt == baudDivisor) begin
				baudCnt <= 8'h00; // [R3]
				if (ctrlTwo[usdp_pkg::C2_HIGH_SPEED] || preCnt == usdp_pkg::LOW_SPEED_LAST) begin
					preCnt <= 2'h0;
					tick <= 1'b1;
				end else begin
					preCnt <= preCnt + 2'h1;
				end
			end else begin
				baudCnt <= baudCnt + 8'h01;
			end
		end
	end

	// ----------------------------------------
	// Transmitter
	// ----------------------------------------
	usdp_tx_e txState;
	logic [8:0] holdData;
	logic holdFull;
	logic [8:0] txShift;
	logic [3:0] txIdx;
	logic [3:0] txTick;
	logic [3:0] breakCnt;
	logic txParity;
	logic txSecondStop;
	logic txEmpty;
	logic txIdle;
	logic txLoad;
	logic txBitEnd;
	logic [3:0] lastIdx;
	assign lastIdx = ctrlOne[usdp_pkg::C1_NINE_BIT] ? 4'h8 : 4'h7; // [R1]
	assign txLoad = txOn && txState == TX_IDLE && holdFull;
	assign txBitEnd = tick && txTick == usdp_pkg::TICK_LAST;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			holdFull <= 1'b0;
			holdData <= 9'h000;
		end else if (!txOn) begin
			holdFull <= 1'b0; // [R24]
		end else if (dataWr) begin
			holdFull <= 1'b1; // [R9]
			holdData <= {ctrlOne[usdp_pkg::C1_TX8], wrData};
		end else if (txLoad) begin
			holdFull <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			txState <= TX_IDLE;
			txShift <= 9'h000;
			txIdx <= 4'h0;
			txTick <= 4'h0;
			breakCnt <= 4'h0;
			txParity <= 1'b0;
			txSecondStop <= 1'b0;
		end else if (!txOn) begin
			txState <= TX_IDLE; // [R24]
			txTick <= 4'h0;
		end else if (txState == TX_IDLE) begin
			txTick <= 4'h0;
			txIdx <= 4'h0;
			txParity <= 1'b0;
			txSecondStop <= 1'b0;
			breakCnt <= 4'h0;
			if (holdFull) begin
				txShift <= holdData; // [R9]
				txState <= TX_START;
			end else if (ctrlOne[usdp_pkg::C1_TX_BREAK]) begin
				txState <= TX_BREAK;
			end
		end else begin
			if (tick) begin
				txTick <= txTick + 4'h1;
			end
			if (txBitEnd) begin
				case (txState)
					TX_START: txState <= TX_DATA;
					TX_DATA: begin
						txParity <= txParity ^ txShift[0]; // [R2]
						txShift <= {1'b0, txShift[8:1]}; // [R9]
						txIdx <= txIdx + 4'h1;
						if (txIdx == lastIdx) begin
							txState <= ctrlOne[usdp_pkg::C1_PARITY_EN] ? TX_PARITY : TX_STOP;
						end
					end
					TX_PARITY: txState <= TX_STOP;
					TX_STOP: begin
						if (ctrlOne[usdp_pkg::C1_TWO_STOP] && !txSecondStop) begin
							txSecondStop <= 1'b1; // [R1]
						end else begin
							txState <= TX_IDLE;
						end
					end
					TX_BREAK: begin
						if (breakCnt != usdp_pkg::BREAK_BITS) begin
							breakCnt <= breakCnt + 4'h1;
						end else if (!ctrlOne[usdp_pkg::C1_TX_BREAK]) begin
							txState <= TX_IDLE;
						end
					end
					default: txState <= TX_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			txEmpty <= 1'b1;
		end else if (!portEnable) begin
			txEmpty <= 1'b1; // [R24]
		end else if (txLoad) begin
			txEmpty <= 1'b1; // [R22]
		end else if (wrStrobe && addr == usdp_pkg::ADDR_CTRL_TWO && wrData[usdp_pkg::C2_TX_EN]) begin
			txEmpty <= 1'b1; // [R23]
		end else if (dataWr && armed && statusSnap[usdp_pkg::ST_TX_EMPTY]) begin
			txEmpty <= 1'b0; // [R22]
		end
	end

	// Idle only when nothing is queued, nothing shifts and no break is pending.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			txIdle <= 1'b1;
		end else if (!portEnable) begin
			txIdle <= 1'b1; // [R24]
		end else if (dataWr && armed && statusSnap[usdp_pkg::ST_TX_IDLE]) begin
			txIdle <= 1'b0; // [R21]
		end else begin
			txIdle <= txEmpty && !holdFull && txState == TX_IDLE
				&& !ctrlOne[usdp_pkg::C1_TX_BREAK]; // [R20]
		end
	end

	// ----------------------------------------
	// Receiver
	// ----------------------------------------
	usdp_rx_e rxState;
	logic rxMeta;
	logic rxSync;
	logic [1:0] votes;
	logic voted;
	logic rxNoise;
	logic [8:0] rxShift;
	logic [3:0] rxIdx;
	logic [3:0] rxTick;
	logic rxParityAcc;
	logic rxParityBit;
	logic rxDone;
	logic [8:0] rxWord;
	logic rxParityErr;
	logic rxFrameErr;
	logic rxNoiseErr;
	logic vote;
	assign vote = (votes[0] & votes[1]) | (votes[0] & rxSync) | (votes[1] & rxSync); // [R25]

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rxMeta <= 1'b1;
			rxSync <= 1'b1;
		end else begin
			rxMeta <= rxPin;
			rxSync <= rxMeta;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rxState <= RX_IDLE;
			votes <= 2'h0;
			voted <= 1'b1;
			rxNoise <= 1'b0;
			rxShift <= 9'h000;
			rxIdx <= 4'h0;
			rxTick <= 4'h0;
			rxParityAcc <= 1'b0;
			rxParityBit <= 1'b0;
			rxDone <= 1'b0;
			rxWord <= 9'h000;
			rxParityErr <= 1'b0;
			rxFrameErr <= 1'b0;
			rxNoiseErr <= 1'b0;
		end else if (!rxOn) begin
			rxState <= RX_IDLE; // [R24]
			rxDone <= 1'b0;
		end else begin
			rxDone <= 1'b0;
			if (rxState == RX_IDLE) begin
				rxTick <= 4'h0;
				rxIdx <= 4'h0;
				rxNoise <= 1'b0;
				rxParityAcc <= 1'b0;
				if (!rxSync) begin
					rxState <= RX_START; // [R17]
				end
			end else if (tick) begin
				rxTick <= rxTick + 4'h1;
				if (rxTick == usdp_pkg::VOTE_FIRST) begin
					votes[0] <= rxSync; // [R25]
				end
				if (rxTick == usdp_pkg::VOTE_SECOND) begin
					votes[1] <= rxSync; // [R25]
				end
				if (rxTick == usdp_pkg::VOTE_LAST) begin
					voted <= vote;
					if (votes[0] != votes[1] || votes[0] != rxSync) begin
						rxNoise <= 1'b1; // [R25]
					end
					if (rxState == RX_STOP) begin
						rxDone <= 1'b1; // [R10]
						rxFrameErr <= !vote; // [R14]
						rxNoiseErr <= rxNoise || votes[0] != votes[1] || votes[0] != rxSync;
						rxParityErr <= ctrlOne[usdp_pkg::C1_PARITY_EN] && (rxParityBit
							!= (rxParityAcc ^ ctrlOne[usdp_pkg::C1_PARITY_ODD])); // [R12]
						rxWord <= ctrlOne[usdp_pkg::C1_NINE_BIT] ? rxShift
							: {1'b0, rxShift[8:1]};
						rxState <= RX_IDLE; // [R17]
					end
				end
				if (rxTick == usdp_pkg::TICK_LAST) begin
					case (rxState)
						RX_START: rxState <= voted ? RX_IDLE : RX_DATA;
						RX_DATA: begin
							rxShift <= {voted, rxShift[8:1]}; // [R10]
							rxParityAcc <= rxParityAcc ^ voted; // [R2]
							rxIdx <= rxIdx + 4'h1;
							if (rxIdx == lastIdx) begin
								rxState <= ctrlOne[usdp_pkg::C1_PARITY_EN] ? RX_PARITY : RX_STOP;
							end
						end
						RX_PARITY: begin
							rxParityBit <= voted;
							rxState <= RX_STOP;
						end
						default: rxState <= rxState;
					endcase
				end
			end
		end
	end

	// ----------------------------------------
	// Receive queue and receive flags
	// ----------------------------------------
	logic [8:0] queue [0:1];
	logic head;
	logic [1:0] count;
	logic push;
	logic pop;
	logic accept;
	logic overrun;
	logic rxAvail;
	logic parityFlag;
	logic noiseFlag;
	logic framingFlag;
	logic errClear;
	assign accept = rxDone && (!ctrlTwo[usdp_pkg::C2_ADDR_DETECT]
		|| (ctrlOne[usdp_pkg::C1_NINE_BIT] ? rxWord[8] : rxWord[7])); // [R5]
	assign pop = dataRd && count != 2'h0;
	assign push = accept && !overrun && count != 2'h2; // [R15]
	assign errClear = armed && (dataRd || dataWr); // [R16]

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			head <= 1'b0;
			count <= 2'h0;
			queue[0] <= 9'h000;
			queue[1] <= 9'h000;
		end else if (!rxOn) begin
			head <= 1'b0; // [R24]
			count <= 2'h0;
		end else begin
			if (push) begin
				queue[head ^ count[0]] <= rxWord; // [R4]
			end
			if (pop) begin
				head <= ~head;
			end
			count <= count + {1'b0, push} - {1'b0, pop}; // [R4]
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			overrun <= 1'b0;
		end else if (!portEnable) begin
			overrun <= 1'b0; // [R24]
		end else if (accept && (overrun || count == 2'h2)) begin
			overrun <= 1'b1; // [R15]
		end else if (errClear) begin
			overrun <= 1'b0; // [R16]
		end
	end

	// Error flags are only set with a queued character, so an overrun never sets them.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			parityFlag <= 1'b0;
			noiseFlag <= 1'b0;
			framingFlag <= 1'b0;
		end else if (!portEnable) begin
			parityFlag <= 1'b0; // [R24]
			noiseFlag <= 1'b0;
			framingFlag <= 1'b0;
		end else if (push) begin
			parityFlag <= rxParityErr | (parityFlag & ~errClear); // [R12]
			noiseFlag <= rxNoiseErr | (noiseFlag & ~errClear); // [R13]
			framingFlag <= rxFrameErr | (framingFlag & ~errClear); // [R14]
		end else if (errClear) begin
			parityFlag <= 1'b0; // [R16]
			noiseFlag <= 1'b0;
			framingFlag <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rxAvail <= 1'b0;
		end else if (!portEnable) begin
			rxAvail <= 1'b0; // [R24]
		end else if (push) begin
			rxAvail <= 1'b1; // [R18]
		end else if (dataRd && armed && statusSnap[usdp_pkg::ST_RX_AVAIL] && count <= 2'h1) begin
			rxAvail <= 1'b0; // [R19]
		end
	end

	assign status = {parityFlag, noiseFlag, framingFlag, overrun,
		rxState == RX_IDLE, rxAvail, txIdle, txEmpty};

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rdData <= 8'h00;
		end else if (rdStrobe) begin
			case (addr)
				usdp_pkg::ADDR_DATA: rdData <= queue[head][7:0]; // [R11]
				usdp_pkg::ADDR_STATUS: rdData <= status;
				usdp_pkg::ADDR_CTRL_ONE: rdData <= {ctrlOne[7:2], queue[head][8], 1'b0};
				usdp_pkg::ADDR_CTRL_TWO: rdData <= ctrlTwo;
				usdp_pkg::ADDR_BAUD: rdData <= baudDivisor;
				default: rdData <= 8'h00;
			endcase
		end else begin
			rdData <= 8'h00;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			txPin <= 1'b1;
			txOe <= 1'b0;
			txPullupOff <= 1'b0;
			rxPullupOff <= 1'b0;
		end else begin
			txOe <= txOn; // [R7] [R8]
			txPullupOff <= txOn; // [R7] [R8]
			rxPullupOff <= rxOn; // [R7] [R8]
			case (txState)
				TX_START: txPin <= 1'b0;
				TX_DATA: txPin <= txShift[0]; // [R9]
				TX_PARITY: txPin <= txParity ^ ctrlOne[usdp_pkg::C1_PARITY_ODD]; // [R2]
				TX_BREAK: txPin <= 1'b0;
				default: txPin <= 1'b1; // [R20]
			endcase
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			irqRequest <= 1'b0;
		end else begin
			irqRequest <= (ctrlTwo[usdp_pkg::C2_RX_IE] & (rxAvail | overrun))
				| (ctrlTwo[usdp_pkg::C2_TX_IDLE_IE] & txIdle)
				| (ctrlTwo[usdp_pkg::C2_TX_EMPTY_IE] & txEmpty); // [R6]
		end
	end
endmodule // usdp_serial_port
`default_nettype wire

// ### sim/usdp_asserts.sv
// Checker of register port and pin relations of the serial port.
`timescale 1ns/1ps
`default_nettype none
module usdp_asserts (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [2:0] addr,
	input wire logic wrStrobe,
	input wire logic rdStrobe,
	input wire logic [7:0] rdData,
	input wire logic txPin,
	input wire logic txOe,
	input wire logic txPullupOff,
	input wire logic rxPullupOff
);
	// ----------------------------------------
	// Sequences
	// ----------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	sequence s_stat_read;
		rdStrobe && addr == usdp_pkg::ADDR_STATUS;
	endsequence
	sequence s_idle_seen;
		s_stat_read ##1 rdData[usdp_pkg::ST_TX_IDLE];
	endsequence
	sequence s_data_write;
		wrStrobe && addr == usdp_pkg::ADDR_DATA && txOe;
	endsequence
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_read_stands: assert property (!$past(rdStrobe) |-> rdData == 8'h00)
		else $error("read data not zero outside an answer");
	a_unmapped_zero: assert property (rdStrobe && addr > usdp_pkg::ADDR_BAUD |=> rdData == 8'h00)
		else $error("unmapped read not zero");
	a_tx_start: assert property (s_idle_seen ##1 s_data_write |-> ##[1:6] !txPin)
		else $error("no start bit after write to idle transmitter");
	a_idle_empty: assert property (s_stat_read |=> !rdData[1] || rdData[0])
		else $error("transmitter idle without empty holding register");
	a_idle_line: assert property (s_idle_seen |-> txPin)
		else $error("transmit line low while idle");
	a_pin_float: assert property (!txOe && !$past(txOe) |-> txPin)
		else $error("transmit line low while released");
	a_pullup_pair: assert property (txPullupOff == txOe)
		else $error("pull-up control differs from pin ownership");
	// Pin ownership may only follow a control write, never the traffic itself.
	a_enable_hold: assert property (($changed(txOe) || $changed(rxPullupOff)) |->
		$past(wrStrobe) || $past(wrStrobe, 2))
		else $error("pin ownership changed without a write");
endmodule // usdp_asserts
`default_nettype wire

// ### sim/usdp_serial_peer.sv
// Model of the far serial device: sends frames and decodes the transmit line.
`timescale 1ns/1ps
`default_nettype none
module usdp_serial_peer #(
	parameter int BIT = 16
) (
	input wire logic clock,
	input wire logic txPin,
	output logic rxPin
);
	logic [7:0] got;
	int nGot = 0;
	initial begin
		rxPin = 1'b1;
	end
	// ----------------------------------------
	// Sender
	// ----------------------------------------
	// Bits go LSB first; the caller supplies parity and stop so errors can be forced.
	// A glitch index of zero or more inverts that bit for one clock inside the vote window.
	task automatic send(input logic [9:0] bits, input int n, input int glitch);
		@(posedge clock);
		rxPin <= 1'b0;
		repeat (BIT) @(posedge clock);
		for (int i = 0; i < n; i++) begin
			rxPin <= bits[i];
			if (i == glitch) begin
				repeat (9) @(posedge clock);
				rxPin <= ~bits[i];
				@(posedge clock);
				rxPin <= bits[i];
				repeat (BIT - 10) @(posedge clock);
			end else begin
				repeat (BIT) @(posedge clock);
			end
		end
		rxPin <= 1'b1;
		repeat (BIT) @(posedge clock);
	endtask
	// ----------------------------------------
	// Receiver
	// ----------------------------------------
	// Samples at bit centres; only eight data bits, as the bench sends no ninth bit.
	always begin
		@(negedge txPin);
		repeat (BIT / 2) @(posedge clock);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge clock);
			got[i] = txPin;
		end
		nGot = nGot + 1;
	end
endmodule // usdp_serial_peer
`default_nettype wire

// ### sim/tb_top.sv
// Self-checking bench of the serial port data path.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clock;
	logic rstn;
	logic [2:0] addr;
	logic [7:0] wrData;
	logic wrStrobe;
	logic rdStrobe;
	logic [7:0] rdData;
	logic rxPin;
	logic txPin;
	logic txOe;
	logic txPullupOff;
	logic rxPullupOff;
	logic irqRequest;
	int nErrors = 0;
	int checks = 0;
	usdp_serial_port u_usdp_serial_port (.clock(clock), .rstn(rstn), .addr(addr),
		.wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
		.rxPin(rxPin), .txPin(txPin), .txOe(txOe), .txPullupOff(txPullupOff),
		.rxPullupOff(rxPullupOff), .irqRequest(irqRequest));
	usdp_serial_peer u_usdp_serial_peer (.clock(clock), .txPin(txPin), .rxPin(rxPin));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			nErrors++;
			$display("ERROR %s expected %h seen %h", name, e, g);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		wrStrobe <= 1'b1;
		addr <= a;
		wrData <= d;
		@(posedge clock);
		wrStrobe <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge clock);
		rdStrobe <= 1'b1;
		addr <= a;
		@(posedge clock);
		rdStrobe <= 1'b0;
		#1;
		chk("rdData", e, rdData);
	endtask
	task automatic wait_byte(input int n, input logic [7:0] e);
		for (int k = 0; k < 400 && u_usdp_serial_peer.nGot < n; k++)
			@(posedge clock);
		chk("txCount", n[7:0], u_usdp_serial_peer.nGot[7:0]);
		chk("txByte", e, u_usdp_serial_peer.got);
	endtask
	task automatic print_verdict;
		if (nErrors == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Clock and watchdog
	// ----------------------------------------
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	// The whole sequence needs about 2500 cycles; the margin covers slow bit timing.
	initial begin
		repeat (8000) @(posedge clock);
		nErrors++;
		print_verdict;
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		rstn = 1'b0;
		addr = 3'h0;
		wrData = 8'h00;
		wrStrobe = 1'b0;
		rdStrobe = 1'b0;
		repeat (10) @(posedge clock);
		rstn <= 1'b1;
		rd(usdp_pkg::ADDR_STATUS, 8'h0b);
		rd(3'h5, 8'h00);
		wr(usdp_pkg::ADDR_CTRL_ONE, 8'h80);
		wr(usdp_pkg::ADDR_BAUD, 8'h00);
		wr(usdp_pkg::ADDR_CTRL_TWO, 8'he4);
		repeat (3) @(posedge clock);
		chk("pins", 8'h07, {5'h00, txOe, txPullupOff, rxPullupOff});
		rd(usdp_pkg::ADDR_STATUS, 8'h0b);
		wr(usdp_pkg::ADDR_DATA, 8'ha5);
		repeat (4) @(posedge clock);
		rd(usdp_pkg::ADDR_STATUS, 8'h09);
		wr(usdp_pkg::ADDR_DATA, 8'h3c);
		rd(usdp_pkg::ADDR_STATUS, 8'h08);
		wait_byte(1, 8'ha5);
		wait_byte(2, 8'h3c);
		repeat (40) @(posedge clock);
		rd(usdp_pkg::ADDR_STATUS, 8'h0b);
		fork
			u_usdp_serial_peer.send({2'b01, 8'h3c}, 9, -1);
			begin
				repeat (40) @(posedge clock);
				rd(usdp_pkg::ADDR_STATUS, 8'h03);
			end
		join
		u_usdp_serial_peer.send({2'b01, 8'hc3}, 9, -1);
		u_usdp_serial_peer.send({2'b01, 8'h11}, 9, -1);
		repeat (4) @(posedge clock);
		chk("irq", 8'h01, {7'h00, irqRequest});
		rd(usdp_pkg::ADDR_STATUS, 8'h1f);
		rd(usdp_pkg::ADDR_DATA, 8'h3c);
		rd(usdp_pkg::ADDR_STATUS, 8'h0f);
		rd(usdp_pkg::ADDR_DATA, 8'hc3);
		rd(usdp_pkg::ADDR_STATUS, 8'h0b);
		chk("irq", 8'h00, {7'h00, irqRequest});
		wr(usdp_pkg::ADDR_CTRL_ONE, 8'ha0);
		u_usdp_serial_peer.send({2'b10, 8'h07}, 10, -1);
		u_usdp_serial_peer.send({2'b11, 8'h07}, 10, -1);
		rd(usdp_pkg::ADDR_STATUS, 8'h8f);
		rd(usdp_pkg::ADDR_DATA, 8'h07);
		rd(usdp_pkg::ADDR_STATUS, 8'h0f);
		rd(usdp_pkg::ADDR_DATA, 8'h07);
		// Odd parity wants a clear parity bit when the data hold three ones.
		wr(usdp_pkg::ADDR_CTRL_ONE, 8'hb0);
		u_usdp_serial_peer.send({2'b10, 8'h07}, 10, -1);
		rd(usdp_pkg::ADDR_STATUS, 8'h0f);
		rd(usdp_pkg::ADDR_DATA, 8'h07);
		wr(usdp_pkg::ADDR_CTRL_ONE, 8'h80);
		// With address detection on, a character whose top bit is clear must vanish.
		wr(usdp_pkg::ADDR_CTRL_TWO, 8'hf4);
		u_usdp_serial_peer.send({2'b01, 8'h01}, 9, -1);
		u_usdp_serial_peer.send({2'b01, 8'h81}, 9, -1);
		rd(usdp_pkg::ADDR_STATUS, 8'h0f);
		rd(usdp_pkg::ADDR_DATA, 8'h81);
		wr(usdp_pkg::ADDR_CTRL_TWO, 8'he4);
		u_usdp_serial_peer.send({2'b00, 8'h5a}, 9, -1);
		rd(usdp_pkg::ADDR_STATUS, 8'h2f);
		// A one-clock glitch in the vote window keeps the bit but must raise noise.
		u_usdp_serial_peer.send({2'b01, 8'h5a}, 9, 2);
		rd(usdp_pkg::ADDR_STATUS, 8'h6f);
		// Disabling with a byte and an error still pending shows both are wiped.
		wr(usdp_pkg::ADDR_CTRL_ONE, 8'h00);
		repeat (3) @(posedge clock);
		chk("pins", 8'h00, {5'h00, txOe, txPullupOff, rxPullupOff});
		rd(usdp_pkg::ADDR_STATUS, 8'h0b);
		rd(usdp_pkg::ADDR_CTRL_TWO, 8'h24);
		print_verdict;
	end
endmodule // tb_top
bind usdp_serial_port usdp_asserts u_usdp_asserts (.clock(clock), .rstn(rstn), .addr(addr),
	.wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .txPin(txPin),
	.txOe(txOe), .txPullupOff(txPullupOff), .rxPullupOff(rxPullupOff));
`default_nettype wire
